/* File: verilog/ivcr_pkg.sv */
// Constants and types shared by both ends of the interrupt vector/channel block
`default_nettype none
package ivcr_pkg;
    // ------------------------------------------------------------
    // Register offsets (printed register numbers)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STD_CHANNEL_MASK_HIGH = 8'hf5;
    localparam logic [7:0] OFS_EXT_VECTOR_AND_TOPLEVEL_SELECT = 8'hf6;
    localparam logic [7:0] OFS_STD_CHANNEL_MASK_LOW = 8'hf6;
    localparam logic [7:0] OFS_NESTED_HOLD_CONTROL = 8'hf7;
    localparam logic [7:0] OFS_STD_TRIGGER_EDGE_HIGH = 8'hf7;
    localparam logic [7:0] OFS_STD_TRIGGER_EDGE_LOW = 8'hf8;
    localparam logic [7:0] OFS_STD_PENDING_HIGH = 8'hf9;
    localparam logic [7:0] OFS_STD_PENDING_LOW = 8'hfa;
    localparam logic [7:0] OFS_STD_VECTOR_AND_WINNER = 8'hfb;
    localparam logic [7:0] OFS_STD_PRIORITY_HIGH = 8'hfc;
    localparam logic [7:0] OFS_STD_PRIORITY_LOW = 8'hfd;
    // Controller registers of the core end
    localparam logic [7:0] OFS_CORE_CONTROL = 8'h10;
    localparam logic [7:0] OFS_CORE_STATUS = 8'h11;
    localparam logic [7:0] OFS_CORE_HOLD_LEVEL = 8'h12;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int POS_EDGE_SEL = 3;
    localparam int POS_TL_SRC = 2;
    localparam int POS_A0_SRC = 1;
    localparam int POS_WAIT_EN = 0;
    localparam int POS_NONMASK = 7;
    localparam logic [3:0] RST_EXT_LOW = 4'h6;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PRIO = 8'hff;
    localparam logic [3:0] RST_WINNER = 4'hf;
    localparam logic [1:0] RST_PRIO_I = 2'h3;
    localparam int NUM_CHAN = 9;
    localparam int NUM_HOLD = 7;
    localparam logic [3:0] CODE_I0 = 4'h8;
    localparam logic [2:0] LVL_LOWEST = 3'h7;
    // Arbitration sample period in clocks
    localparam int ARB_PERIOD = 5;
    // Core control bit positions
    localparam int POS_GIE = 0;
    localparam int POS_TLI = 1;
    localparam int POS_NEST = 2;
    // Core arbitration states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ARB = 4'b0010,
        ST_SERVE = 4'b0100,
        ST_TOP = 4'b1000
    } ivcr_state_type;
endpackage
`default_nettype wire

/* File: verilog/ivcr_if.sv */
// Link between the channel register bank and the CPU core end
`default_nettype none
interface ivcr_if;
    logic [7:0] addr;       // Register address
    logic [7:0] wdata;      // Write data
    logic wr;               // Write strobe
    logic rd;               // Read strobe
    logic [7:0] rdata;      // Read data, one cycle after rd
    logic gie;              // Global maskable enable
    logic tl_mode;          // Top-level mode bit
    logic tl_pend;          // Top-level pending
    logic tl_ack;           // Top-level acknowledge pulse
    logic arb_start;        // Arbitration start phase pulse
    logic chan_req;         // Any channel request (level)
    logic [3:0] winner;     // Latched winner code
    logic [2:0] win_level;  // Priority level of winner
    logic ch_ack;           // Channel acknowledge pulse
    logic [3:0] ack_code;   // Channel being acknowledged
    logic tl_req;           // Top-level request
    logic [6:0] hold_set;   // Set hold-level bits pulse
    logic [6:0] hold_clr;   // Clear hold-level bits pulse
    modport dev (input addr, wdata, wr, rd, gie, tl_mode, tl_pend, arb_start, ch_ack,
        ack_code, hold_set, hold_clr, output rdata, chan_req, winner, win_level, tl_req);
    modport core (output addr, wdata, wr, rd, gie, tl_mode, tl_pend, arb_start, ch_ack,
        ack_code, hold_set, hold_clr, input rdata, chan_req, winner, win_level, tl_req);
endinterface
`default_nettype wire

/* File: verilog/ivcr_dev.sv */
// Channel register bank: source select, masks, edges, pending, winner, priority
// What this block does
// - External vector high nibble not reset
// - Edge select picks nonmaskable input edge
// - Top-level source: watchdog or nonmaskable pin
// - Channel A0 source: watchdog or pin
// - Wait enable gates memory wait input
// - Nonmaskable bit set-only, reset clears
// - Top-level request gating by nonmaskable bit
// - Hold-level bits track preempted nested levels
// - Channel I0 mask enables its interrupt
// - Eight masks for E0 to H1
// - Edge bit selects falling or rising trigger
// - Software sets I0 rising for serial
// - Software sets bus controller channels rising
// - Edge ignored during edge-register write
// - Edge sets pending, acknowledge clears
// - Software one sets pending bit
// - Standard vector high bits not reset
// - Four-bit winner code in bits 4:1
// - Winner latched at arbitration start
// - Vector register bit 0 reads zero
// - Pair I priority, odd/even low bit
// - Level zero highest, seven lowest
//
// The strobed register port was chosen for this implementation.
`default_nettype none
module ivcr_dev
    import ivcr_pkg::*;
(
    input wire logic clk,                   // 250 MHz clock
    input wire logic rst_b,                 // Async reset, active low
    ivcr_if.dev bus,                        // Core side
    input wire logic [NUM_CHAN-1:0] chan_line, // Channel E0..I0 lines
    input wire logic nmi_line,              // Nonmaskable pin
    input wire logic wdog_eoc,              // Watchdog end of count
    input wire logic ext_a0_line,           // External channel A0 pin
    input wire logic memory_wait_input,     // External wait pin
    output logic ext_channel_a0,            // Routed channel A0 source
    output logic ext_wait,                  // Gated wait to memory logic
    output logic tl_event                   // Top-level trigger event
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:4] ext_vec_ff;
    logic [3:0] ext_sel_ff;
    logic nonmask_ff;
    logic [6:0] hold_ff;
    logic [NUM_CHAN-1:0] mask_ff, edge_ff, pend_ff, line_ff;
    logic [7:5] std_vec_ff;
    logic [3:0] winner_ff;
    logic [7:0] prio_low_ff;
    logic [1:0] prio_i_ff;
    logic [7:0] rdata_ff;
    logic tl_src_ff, tl_event_ff, chan_req_ff, tl_req_ff;
    logic ext_a0_ff, ext_wait_ff;
    logic [2:0] win_level_ff;
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire wr_ext = bus.wr && bus.addr == OFS_EXT_VECTOR_AND_TOPLEVEL_SELECT;
    wire wr_nhc = bus.wr && bus.addr == OFS_NESTED_HOLD_CONTROL;
    wire wr_mh = bus.wr && bus.addr == OFS_STD_CHANNEL_MASK_HIGH;
    wire wr_ml = bus.wr && bus.addr == OFS_STD_CHANNEL_MASK_LOW;
    wire wr_eh = bus.wr && bus.addr == OFS_STD_TRIGGER_EDGE_HIGH;
    wire wr_el = bus.wr && bus.addr == OFS_STD_TRIGGER_EDGE_LOW;
    wire wr_ph = bus.wr && bus.addr == OFS_STD_PENDING_HIGH;
    wire wr_pl = bus.wr && bus.addr == OFS_STD_PENDING_LOW;
    wire wr_sv = bus.wr && bus.addr == OFS_STD_VECTOR_AND_WINNER;
    wire wr_pr = bus.wr && bus.addr == OFS_STD_PRIORITY_HIGH;
    wire wr_prl = bus.wr && bus.addr == OFS_STD_PRIORITY_LOW;
    wire edge_wr = wr_eh || wr_el;
    // Level of channel n: pair bits then odd/even bit
    function automatic logic [2:0] chan_level(input logic [3:0] code,
        input logic [7:0] lo, input logic [1:0] hi);
        logic [2:0] pair;
        pair = 3'h0;
        if (code == CODE_I0) begin
            return {hi, 1'b0};
        end
        pair = code[3:1];
        return {lo[2*pair+1], lo[2*pair], code[0]};
    endfunction
    // ------------------------------------------------------------
    // Edge detection and pending
    // ------------------------------------------------------------
    wire [NUM_CHAN-1:0] rise = chan_line & ~line_ff;
    wire [NUM_CHAN-1:0] fall = ~chan_line & line_ff;
    wire [NUM_CHAN-1:0] trig = ((rise & edge_ff) | (fall & ~edge_ff))
        & {NUM_CHAN{~edge_wr}};
    wire [NUM_CHAN-1:0] sw_set = {wr_ph & bus.wdata[0],
        {8{wr_pl}} & bus.wdata};
    logic [NUM_CHAN-1:0] ack_vec;
    always_comb begin
        ack_vec = '0;
        if (bus.ch_ack && bus.ack_code <= CODE_I0) begin
            ack_vec[bus.ack_code] = 1'b1;
        end
    end
    // Set wins over acknowledge clear
    wire [NUM_CHAN-1:0] nxt_pend = (pend_ff & ~ack_vec) | trig | sw_set;
    wire [NUM_CHAN-1:0] active = pend_ff & mask_ff & {NUM_CHAN{bus.gie}};
    // Arbitration winner: lowest level, then lowest code
    logic [3:0] best_code;
    logic [2:0] best_lvl;
    logic best_hit;
    always_comb begin
        best_code = '0;
        best_lvl = LVL_LOWEST;
        best_hit = 1'b0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (active[i] && (!best_hit ||
                chan_level(4'(i), prio_low_ff, prio_i_ff) < best_lvl)) begin
                best_hit = 1'b1;
                best_code = 4'(i);
                best_lvl = chan_level(4'(i), prio_low_ff, prio_i_ff);
            end
        end
    end
    // ------------------------------------------------------------
    // Top-level source and gating
    // ------------------------------------------------------------
    wire tl_src = ext_sel_ff[POS_TL_SRC] ? nmi_line : wdog_eoc;
    wire tl_edge = ext_sel_ff[POS_EDGE_SEL] ? (tl_src & ~tl_src_ff)
        : (~tl_src & tl_src_ff);
    wire nxt_tl_req = nonmask_ff ? bus.tl_pend
        : (bus.gie & bus.tl_mode & bus.tl_pend);
    wire nxt_a0 = ext_sel_ff[POS_A0_SRC] ? ext_a0_line : wdog_eoc;
    wire nxt_wait = ext_sel_ff[POS_WAIT_EN] & memory_wait_input;
    // Read mux
    logic [7:0] nxt_rdata;
    always_comb begin
        case (bus.addr)
            OFS_STD_CHANNEL_MASK_HIGH: nxt_rdata = {7'h00, mask_ff[8]};
            OFS_STD_CHANNEL_MASK_LOW: nxt_rdata = mask_ff[7:0];
            OFS_NESTED_HOLD_CONTROL: nxt_rdata = {nonmask_ff, hold_ff};
            OFS_STD_TRIGGER_EDGE_LOW: nxt_rdata = edge_ff[7:0];
            OFS_STD_PENDING_HIGH: nxt_rdata = {7'h00, pend_ff[8]};
            OFS_STD_PENDING_LOW: nxt_rdata = pend_ff[7:0];
            OFS_STD_VECTOR_AND_WINNER: nxt_rdata = {std_vec_ff, winner_ff, 1'b0};
            OFS_STD_PRIORITY_HIGH: nxt_rdata = {6'h00, prio_i_ff};
            OFS_STD_PRIORITY_LOW: nxt_rdata = prio_low_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end
    // ------------------------------------------------------------
    // Registers with reset
    // ------------------------------------------------------------
    // Shared offsets 0xf6/0xf7 write both the page-0 and channel copies
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_sel_ff <= RST_EXT_LOW;
            nonmask_ff <= 1'b0;
            hold_ff <= '0;
            mask_ff <= '0;
            edge_ff <= '0;
            pend_ff <= '0;
            line_ff <= '0;
            winner_ff <= RST_WINNER;
            prio_low_ff <= RST_PRIO;
            prio_i_ff <= RST_PRIO_I;
            rdata_ff <= RST_ZERO;
            tl_src_ff <= 1'b0;
            tl_event_ff <= 1'b0;
            chan_req_ff <= 1'b0;
            tl_req_ff <= 1'b0;
            ext_a0_ff <= 1'b0;
            ext_wait_ff <= 1'b0;
            win_level_ff <= LVL_LOWEST;
        end else begin
            if (wr_ext) ext_sel_ff <= bus.wdata[3:0];
            if (wr_nhc && bus.wdata[POS_NONMASK]) nonmask_ff <= 1'b1;
            hold_ff <= (hold_ff & ~bus.hold_clr) | bus.hold_set;
            if (wr_mh) mask_ff[8] <= bus.wdata[0];
            if (wr_ml) mask_ff[7:0] <= bus.wdata;
            if (wr_eh) edge_ff[8] <= bus.wdata[0];
            if (wr_el) edge_ff[7:0] <= bus.wdata;
            pend_ff <= nxt_pend;
            line_ff <= chan_line;
            if (bus.arb_start && best_hit) begin
                winner_ff <= best_code;
                win_level_ff <= best_lvl;
            end
            if (wr_pr) prio_i_ff <= bus.wdata[1:0];
            if (wr_prl) prio_low_ff <= bus.wdata;
            rdata_ff <= nxt_rdata;
            tl_src_ff <= tl_src;
            tl_event_ff <= tl_edge;
            chan_req_ff <= |active;
            tl_req_ff <= nxt_tl_req;
            ext_a0_ff <= nxt_a0;
            ext_wait_ff <= nxt_wait;
        end
    end
    // Vector high bits keep no reset value
    always_ff @(posedge clk) begin
        if (wr_ext) ext_vec_ff <= bus.wdata[7:4];
        if (wr_sv) std_vec_ff <= bus.wdata[7:5];
    end
    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bus.rdata = rdata_ff;
    assign bus.chan_req = chan_req_ff;
    assign bus.winner = winner_ff;
    assign bus.win_level = win_level_ff;
    assign bus.tl_req = tl_req_ff;
    assign ext_channel_a0 = ext_a0_ff;
    assign ext_wait = ext_wait_ff;
    assign tl_event = tl_event_ff;
endmodule
`default_nettype wire

/* File: verilog/ivcr_core.sv */
// CPU core end: arbitration timing, acknowledge, nested hold tracking
`default_nettype none
module ivcr_core
    import ivcr_pkg::*;
(
    input wire logic clk,            // 250 MHz clock
    input wire logic rst_b,          // Async reset, active low
    ivcr_if.core bus,                // Device side
    input wire logic [7:0] sw_addr,  // Software address
    input wire logic [7:0] sw_wdata, // Software write data
    input wire logic sw_wr,          // Software write strobe
    input wire logic sw_rd,          // Software read strobe
    output logic [7:0] sw_rdata,     // Read data, one cycle later
    input wire logic tl_event,       // Top-level trigger event
    input wire logic iret            // Return from routine pulse
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ivcr_state_type state_ff, nxt_state;
    logic [2:0] ctrl_ff;
    logic tl_pend_ff, arb_ff, ack_ff, sel_ff;
    logic [2:0] cnt_ff;
    logic [2:0] cur_lvl_ff;
    logic [7:0] rdata_ff, addr_ff;
    logic [6:0] hset_ff, hclr_ff, hold_ff;
    logic [3:0] ackc_ff;
    wire own = sw_addr == OFS_CORE_CONTROL || sw_addr == OFS_CORE_STATUS
        || sw_addr == OFS_CORE_HOLD_LEVEL;
    wire cnt_wrap = cnt_ff == 3'(ARB_PERIOD - 1);
    wire nest = ctrl_ff[POS_NEST];
    wire preempt = nest && bus.win_level < cur_lvl_ff;
    wire [6:0] lvl_bit = (cur_lvl_ff < 3'(NUM_HOLD)) ? 7'(1 << cur_lvl_ff) : 7'h00;
    // Next-state decision
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (cnt_wrap) nxt_state = ST_ARB;
            ST_ARB: nxt_state = bus.tl_req ? ST_TOP : (bus.chan_req ? ST_SERVE : ST_IDLE);
            ST_SERVE: nxt_state = ST_IDLE;
            ST_TOP: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end
    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ST_IDLE;
            ctrl_ff <= '0;
            tl_pend_ff <= 1'b0;
            cnt_ff <= '0;
            arb_ff <= 1'b0;
            ack_ff <= 1'b0;
            ackc_ff <= '0;
            cur_lvl_ff <= LVL_LOWEST;
            hset_ff <= '0;
            hclr_ff <= '0;
            hold_ff <= '0;
            rdata_ff <= '0;
            addr_ff <= '0;
            sel_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= cnt_wrap ? 3'h0 : cnt_ff + 3'h1;
            arb_ff <= cnt_wrap;
            ack_ff <= state_ff == ST_SERVE;
            ackc_ff <= bus.winner;
            hset_ff <= '0;
            hclr_ff <= '0;
            if (sw_wr && sw_addr == OFS_CORE_CONTROL) ctrl_ff <= sw_wdata[2:0];
            // Pending set wins over acknowledge
            tl_pend_ff <= tl_event || (tl_pend_ff && state_ff != ST_TOP)
                || (sw_wr && sw_addr == OFS_CORE_STATUS && sw_wdata[0]);
            if (state_ff == ST_SERVE) begin
                if (preempt) begin
                    hset_ff <= lvl_bit;
                    hold_ff <= hold_ff | lvl_bit;
                end
                if (nest) cur_lvl_ff <= bus.win_level;
                ctrl_ff[POS_GIE] <= 1'b0;
            end else if (iret) begin
                ctrl_ff[POS_GIE] <= 1'b1;
                if (nest && hold_ff != 7'h00) begin
                    for (int i = NUM_HOLD - 1; i >= 0; i--) begin
                        if (hold_ff[i] && 3'(i) > cur_lvl_ff) begin
                            hclr_ff <= 7'(1 << i);
                            hold_ff <= hold_ff & ~7'(1 << i);
                            cur_lvl_ff <= 3'(i);
                        end
                    end
                end else begin
                    cur_lvl_ff <= LVL_LOWEST;
                end
            end
            sel_ff <= own;
            addr_ff <= sw_addr;
            rdata_ff <= sw_addr == OFS_CORE_STATUS ? {4'h0, bus.winner[2:0], tl_pend_ff}
                : sw_addr == OFS_CORE_HOLD_LEVEL ? {1'b0, hold_ff} : {5'h00, ctrl_ff};
        end
    end
    // ------------------------------------------------------------
    // Outputs to device and software
    // ------------------------------------------------------------
    assign bus.addr = sw_addr;
    assign bus.wdata = sw_wdata;
    assign bus.wr = sw_wr && !own;
    assign bus.rd = sw_rd && !own;
    assign bus.gie = ctrl_ff[POS_GIE];
    assign bus.tl_mode = ctrl_ff[POS_TLI];
    assign bus.tl_pend = tl_pend_ff;
    assign bus.arb_start = arb_ff;
    assign bus.ch_ack = ack_ff;
    assign bus.ack_code = ackc_ff;
    assign bus.hold_set = hset_ff;
    assign bus.hold_clr = hclr_ff;
    assign sw_rdata = sel_ff ? rdata_ff : bus.rdata;
endmodule
`default_nettype wire

/* File: tb/ivcr_chk.sv */
// Checker on the link between the channel bank and the core end
`default_nettype none
module ivcr_chk
    import ivcr_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic [7:0] addr, // Address
    input wire logic rd, // Read strobe
    input wire logic [7:0] rdata, // Read data
    input wire logic gie, // Global enable
    input wire logic tl_mode, // Top-level mode
    input wire logic tl_pend, // Top-level pending
    input wire logic arb_start, // Arbitration pulse
    input wire logic chan_req, // Channel request
    input wire logic [3:0] winner, // Winner code
    input wire logic [2:0] win_level, // Winner level
    input wire logic ch_ack, // Channel acknowledge
    input wire logic [3:0] ack_code, // Acknowledged channel
    input wire logic tl_req, // Top-level request
    input wire logic [6:0] hold_set, // Hold set pulses
    input wire logic [6:0] hold_clr // Hold clear pulses
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // Link properties
    // ------------------------------------------------------------
    a_winner_held: assert property ($changed(winner) |-> $past(arb_start))
        else $error("winner changed outside arbitration start");
    a_arb_spacing: assert property (arb_start |=> !arb_start [*4] ##1 arb_start)
        else $error("arbitration start spacing wrong");
    a_winner_code: assert property (winner <= CODE_I0 || winner == RST_WINNER)
        else $error("winner code out of range");
    a_vector_read: assert property (rd && addr == OFS_STD_VECTOR_AND_WINNER |=>
        rdata[0] == 1'b0 && rdata[4:1] == $past(winner))
        else $error("vector register read wrong");
    a_level_low_bit: assert property (win_level[0] == winner[0])
        else $error("winner level low bit wrong");
    a_req_needs_gie: assert property (chan_req |-> $past(gie))
        else $error("channel request without global enable");
    a_top_request: assert property (tl_pend && gie && tl_mode |=> tl_req)
        else $error("top-level request missing");
    a_top_cause: assert property (tl_req |-> $past(tl_pend))
        else $error("top-level request without pending");
    a_ack_code: assert property (ch_ack |-> ack_code <= CODE_I0)
        else $error("acknowledge code out of range");
    a_hold_apart: assert property ((hold_set & hold_clr) == 7'h0)
        else $error("hold level set and cleared together");
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Testbench joining both ends of the vector/channel link
`default_nettype none
module tb_top import ivcr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] sw_addr = 8'h00, sw_wdata = 8'h00, sw_rdata;
    logic sw_wr = 1'b0, sw_rd = 1'b0;
    logic [8:0] chan_line = 9'h000;
    logic nmi_line = 1'b0, ext_a0_line = 1'b1, mem_wait = 1'b1;
    logic wdog = 1'b0, iret = 1'b0;
    logic ext_channel_a0, ext_wait, tl_event;
    int n_fail = 0, total_checks = 0;
    logic [7:0] ra [10] = '{8'hf5, 8'hf6, 8'hf7, 8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'h20};
    logic [7:0] rm [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'h03, 8'hff, 8'hff};
    logic [7:0] re [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1e, 8'h03, 8'hff, 8'h00};
    ivcr_if bus ();
    ivcr_dev i_ivcr_dev (.clk(clk), .rst_b(rst_b), .bus(bus), .chan_line(chan_line),
        .nmi_line(nmi_line), .wdog_eoc(wdog), .ext_a0_line(ext_a0_line),
        .memory_wait_input(mem_wait), .ext_channel_a0(ext_channel_a0),
        .ext_wait(ext_wait), .tl_event(tl_event));
    ivcr_core i_ivcr_core (.clk(clk), .rst_b(rst_b), .bus(bus), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
        .tl_event(tl_event), .iret(iret));
    ivcr_chk i_ivcr_chk (.clk(clk), .rst_b(rst_b), .addr(bus.addr), .rd(bus.rd),
        .rdata(bus.rdata), .gie(bus.gie), .tl_mode(bus.tl_mode), .tl_pend(bus.tl_pend),
        .arb_start(bus.arb_start), .chan_req(bus.chan_req), .winner(bus.winner),
        .win_level(bus.win_level), .ch_ack(bus.ch_ack), .ack_code(bus.ack_code),
        .tl_req(bus.tl_req), .hold_set(bus.hold_set), .hold_clr(bus.hold_clr));
    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1;
        v = sw_rdata;
    endtask
    task automatic rc(input logic [7:0] a, m, e, input string nm);
        logic [7:0] v;
        rd(a, v);
        chk(nm, e, v & m);
    endtask
    // Bounded poll; running out ends the run
    task automatic poll(input logic [7:0] a, m, e, input string nm);
        logic [7:0] v;
        v = ~e;
        for (int i = 0; i < 40 && (v & m) !== e; i++) begin
            rd(a, v);
        end
        chk(nm, e, v & m);
        if ((v & m) !== e) begin
            complete_run();
        end
    endtask
    // ------------------------------------------------------------
    // Clock and test sequence
    // ------------------------------------------------------------
    initial begin
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rc(ra[i], rm[i], re[i], "reset value");
        end
        $display("test reset values done");
        wr(OFS_EXT_VECTOR_AND_TOPLEVEL_SELECT, 8'h03);
        repeat (3) @(posedge clk);
        chk("ext_wait on", 8'h01, {7'h0, ext_wait});
        chk("a0 from pin", 8'h01, {7'h0, ext_channel_a0});
        // Watchdog feeds A0, so the top level takes the pin
        wr(OFS_EXT_VECTOR_AND_TOPLEVEL_SELECT, 8'h04);
        wdog <= 1'b1;
        ext_a0_line <= 1'b0;
        nmi_line <= 1'b1;
        repeat (3) @(posedge clk);
        chk("ext_wait off", 8'h00, {7'h0, ext_wait});
        chk("a0 from watchdog", 8'h01, {7'h0, ext_channel_a0});
        $display("test source routing done");
        repeat (5) @(posedge clk);
        rc(OFS_CORE_STATUS, 8'h01, 8'h00, "rise ignored");
        nmi_line <= 1'b0;
        poll(OFS_CORE_STATUS, 8'h01, 8'h01, "fall pending");
        repeat (6) @(posedge clk);
        rc(OFS_CORE_STATUS, 8'h01, 8'h01, "top held");
        wr(OFS_CORE_CONTROL, 8'h03);
        poll(OFS_CORE_STATUS, 8'h01, 8'h00, "masked top served");
        wr(OFS_CORE_CONTROL, 8'h00);
        wr(OFS_CORE_STATUS, 8'h01);
        rc(OFS_CORE_STATUS, 8'h01, 8'h01, "sw top pending");
        wr(OFS_NESTED_HOLD_CONTROL, 8'h80);
        poll(OFS_CORE_STATUS, 8'h01, 8'h00, "nonmask served");
        wr(OFS_NESTED_HOLD_CONTROL, 8'h00);
        rc(OFS_NESTED_HOLD_CONTROL, 8'h80, 8'h80, "nonmask kept");
        $display("test top level done");
        wr(OFS_STD_TRIGGER_EDGE_HIGH, 8'h01);
        wr(OFS_STD_TRIGGER_EDGE_LOW, 8'h0f);
        chan_line <= 9'h1ff;
        poll(OFS_STD_PENDING_LOW, 8'hff, 8'h0f, "rising edges");
        rc(OFS_STD_PENDING_HIGH, 8'h01, 8'h01, "I0 rising");
        chan_line <= 9'h000;
        poll(OFS_STD_PENDING_LOW, 8'hff, 8'hff, "falling edges");
        $display("test pending done");
        wr(OFS_STD_PRIORITY_LOW, 8'h3f);
        wr(OFS_STD_CHANNEL_MASK_LOW, 8'h42);
        wr(OFS_CORE_CONTROL, 8'h01);
        poll(OFS_STD_PENDING_LOW, 8'hff, 8'hbf, "H0 served");
        rc(OFS_STD_VECTOR_AND_WINNER, 8'h1f, 8'h0c, "winner H0");
        wr(OFS_CORE_CONTROL, 8'h01);
        poll(OFS_STD_PENDING_LOW, 8'hff, 8'hbd, "E1 served");
        rc(OFS_STD_VECTOR_AND_WINNER, 8'h1f, 8'h02, "winner E1");
        wr(OFS_STD_CHANNEL_MASK_HIGH, 8'h01);
        wr(OFS_CORE_CONTROL, 8'h01);
        poll(OFS_STD_PENDING_HIGH, 8'h01, 8'h00, "I0 served");
        rc(OFS_STD_VECTOR_AND_WINNER, 8'h1f, 8'h10, "winner I0");
        $display("test arbitration done");
        // Nested: E1 at level 5 is preempted by H0 at level 0
        wr(OFS_STD_PRIORITY_LOW, 8'h3e);
        wr(OFS_STD_PENDING_LOW, 8'h02);
        rc(OFS_STD_PENDING_LOW, 8'h02, 8'h02, "sw pending");
        wr(OFS_CORE_CONTROL, 8'h05);
        poll(OFS_STD_PENDING_LOW, 8'h02, 8'h00, "E1 nested");
        wr(OFS_STD_PENDING_LOW, 8'h40);
        wr(OFS_CORE_CONTROL, 8'h05);
        poll(OFS_STD_PENDING_LOW, 8'h40, 8'h00, "H0 nested");
        rc(OFS_NESTED_HOLD_CONTROL, 8'h7f, 8'h20, "hold set");
        iret <= 1'b1;
        @(posedge clk);
        iret <= 1'b0;
        rc(OFS_NESTED_HOLD_CONTROL, 8'h7f, 8'h00, "hold cleared");
        $display("test nested done");
        // Edge on E1 in the cycle that writes the edge register
        wr(OFS_CORE_CONTROL, 8'h00);
        fork
            wr(OFS_STD_TRIGGER_EDGE_LOW, 8'h0f);
            @(posedge clk) chan_line <= 9'h002;
        join
        rc(OFS_STD_PENDING_LOW, 8'h02, 8'h00, "edge during write");
        $display("test edge drop done");
        complete_run();
    end
endmodule
`default_nettype wire
